// [iso_split_pkg.sv]
// Shared constants, types and register map for the isochronous split sequencer
`default_nettype none
package iso_split_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ     = 25_000_000;
  localparam int UFRAME_NS  = 125_000;
  localparam int UF_CYCLES  = UFRAME_NS / 1000 * (CLK_HZ / 1_000_000);
  localparam int UF_PER_FRM = 8;
  // ==========================================================================
  // Register offsets
  localparam logic [11:0] OFS_CMD  = 12'h000;
  localparam logic [11:0] OFS_STS  = 12'h004;
  localparam logic [11:0] OFS_IEN  = 12'h008;
  localparam logic [11:0] OFS_CFG  = 12'h00c;
  localparam logic [11:0] OFS_PSC  = 12'h010;
  localparam logic [11:0] OFS_DESC = 12'h040;
  // ==========================================================================
  // Field positions
  localparam int CMD_RUN     = 0;
  localparam int CMD_RESET   = 1;
  localparam int CMD_PER_EN  = 4;
  localparam int CMD_ASY_EN  = 5;
  localparam int CMD_THR_LSB = 16;
  localparam int STS_INT     = 0;
  localparam int STS_ERR     = 1;
  localparam int STS_HALT    = 12;
  localparam int PSC_EN      = 2;
  localparam int PSC_SUSP    = 7;
  localparam int PSC_TST_LSB = 16;
  // ==========================================================================
  // Reset values
  localparam logic [31:0] CMD_RST = 32'h0008_0000;
  localparam logic [31:0] IEN_RST = 32'h0000_0000;
  localparam logic [31:0] PSC_RST = 32'h0000_0000;
  // ==========================================================================
  // Descriptor store
  localparam int NDESC = 8;
  localparam int IDX_W = 3;
  typedef enum logic [2:0] {
    TEST_OFF = 3'h0, TEST_J = 3'h1, TEST_K = 3'h2, TEST_SE0 = 3'h3,
    TEST_PKT = 3'h4, TEST_FORCE = 3'h5
  } test_mode_e;
  typedef enum logic [2:0] {
    RSP_ACK = 3'h0, RSP_NYET = 3'h1, RSP_MDATA = 3'h2, RSP_DATA = 3'h3, RSP_ERR = 3'h4
  } tt_resp_e;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_VISIT = 5'b00010,
    ST_BACK  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_RET   = 5'b10000
  } seq_state_e;
  typedef struct packed {
    logic [7:0]       xfer;
    logic [7:0]       cmask;
    logic [7:0]       smask;
    logic             retired;
    logic             ioc;
    logic [IDX_W-1:0] back_idx;
    logic             back_t;
    logic             cs;
    logic             active;
  } split_iso_descriptor_s;
  typedef struct packed {
    logic             start;
    logic [IDX_W-1:0] idx;
    logic [7:0]       xfer;
  } tt_cmd_s;
endpackage
`default_nettype wire

// [uframe_timer.sv]
// Micro-frame tick divider and micro-frame index
`default_nettype none
module uframe_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  output logic            uf_tick,
  output logic [2:0]      uf_idx
);
  logic [11:0] cnt_r;
  logic [2:0]  uf_r;
  wire         wrap = (cnt_r == 12'(iso_split_pkg::UF_CYCLES - 1));

  assign uf_tick = run & wrap;
  assign uf_idx  = uf_r;

  // ==========================================================================
  // Divider runs only while the controller runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
      uf_r  <= 3'h0;
    end else if (!run) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= wrap ? 12'h000 : cnt_r + 12'h001;
      if (wrap) begin
        uf_r <= uf_r + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [irq_threshold.sv]
// Defers completion and error events to the end of the threshold interval
`default_nettype none
module irq_threshold (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clr,
  input  wire logic       uf_tick,
  input  wire logic [7:0] thresh,
  input  wire logic [1:0] ev,
  output logic [1:0]      fire
);
  logic [7:0] cnt_r;
  logic [1:0] pend_r;
  wire        expire = uf_tick & (cnt_r + 8'h01 >= thresh);

  assign fire = expire ? pend_r : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 8'h00;
      pend_r <= 2'b00;
    end else if (clr) begin
      cnt_r  <= 8'h00;
      pend_r <= 2'b00;
    end else begin
      if (uf_tick) begin
        cnt_r <= expire ? 8'h00 : cnt_r + 8'h01;
      end
      pend_r <= ev | (pend_r & {2{~expire}});
    end
  end
endmodule
`default_nettype wire

// [iso_split_txn_sequencer.sv]
// Isochronous split transaction sequencer with APB registers and port test control
//
// Contract
// - Every active descriptor is visited once per micro-frame, eight per frame.
// - In start-split state the complete-split mask is ignored.
// - Start mask bit set: issue start-split, move descriptor to complete-split state.
// - In complete-split state issue a complete-split where the complete mask bit is set.
// - Micro-frame 0, back link valid: save current, fetch previous, complete its split.
// - Previous split finished: clear active, write back, current to start; only DATA marks retired.
// - Early completion returns to start-split state, skipping remaining complete-splits.
// - Back-linked MDATA before the last complete-split advances previous, keeps active, current left untouched.
// - Micro-frame 1 with start mask bit 0 clear also completes via previous.
// - DATA0 ending previous split updates it, clears active, current to start.
// - Port offers J, K, test packet, forced enable and SE0 NAK test modes.
// - Port testing is supported while halted; not while running; only mode writes are blocked while running, a set mode stays active.
// - Transaction interrupts are maskable; descriptors may request completion interrupts.
// - Completion interrupts wait for the threshold interval, default eight micro-frames.
// - Only one back link is followed, never a chain.
// - Interrupt and error status bits clear by writing ones; the halted bit does not.
`default_nettype none
module iso_split_txn_sequencer (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        tt_cmd_valid,
  output iso_split_pkg::tt_cmd_s      tt_cmd,
  input  wire logic                   tt_resp_valid,
  input  wire iso_split_pkg::tt_resp_e tt_resp,
  output logic                        irq,
  output logic [2:0]                  port_test_mode,
  output logic                        port_suspended,
  output logic                        port_enabled
);
  // ==========================================================================
  // Declarations
  iso_split_pkg::split_iso_descriptor_s mem [iso_split_pkg::NDESC];
  iso_split_pkg::split_iso_descriptor_s sav_r, sav_nxt, cur, prv, tgt, wd;
  iso_split_pkg::seq_state_e st_r, st_nxt;
  iso_split_pkg::tt_cmd_s    cmd_nxt, tt_cmd_r;
  logic [31:0] cmd_r, ien_r, psc_r, prdata_r, rdata;
  logic        sts_int_r, sts_err_r, halted_r, cfg_r, sw_rst_r, idle_q_r;
  logic [2:0]  idx_r, idx_nxt, prv_r, prv_nxt, uf;
  logic        back_r, back_nxt, ret_ss_r, ret_ss_nxt, cmd_v_nxt, tt_cmd_v_r;
  logic        fsm_we;
  logic [2:0]  fsm_wa;
  logic [1:0]  ev, fire;
  logic        uf_tick;

  function automatic logic mask_bit(input logic [7:0] m, input logic [2:0] i);
    mask_bit = m[i];
  endfunction

  function automatic logic last_cs(input logic [7:0] m, input logic [2:0] i);
    last_cs = ((m >> i) >> 1) == 8'h00;
  endfunction

  // ==========================================================================
  // Micro-frame timing and interrupt deferral
  uframe_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (cmd_r[iso_split_pkg::CMD_RUN]),
    .uf_tick (uf_tick),
    .uf_idx  (uf)
  );

  irq_threshold u_thr (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (sw_rst_r),
    .uf_tick (uf_tick),
    .thresh  (cmd_r[iso_split_pkg::CMD_THR_LSB +: 8]),
    .ev      (ev),
    .fire    (fire)
  );

  // ==========================================================================
  // APB decode
  wire acc      = psel & penable;
  wire hit_cmd  = paddr == iso_split_pkg::OFS_CMD;
  wire hit_sts  = paddr == iso_split_pkg::OFS_STS;
  wire hit_ien  = paddr == iso_split_pkg::OFS_IEN;
  wire hit_cfg  = paddr == iso_split_pkg::OFS_CFG;
  wire hit_psc  = paddr == iso_split_pkg::OFS_PSC;
  wire hit_desc = paddr[11:5] == iso_split_pkg::OFS_DESC[11:5] && paddr[1:0] == 2'b00;
  wire [2:0] d_idx = paddr[4:2];
  wire hit_any  = hit_cmd | hit_sts | hit_ien | hit_cfg | hit_psc | hit_desc;
  wire desc_ok  = (st_r == iso_split_pkg::ST_IDLE) & idle_q_r;
  wire wr       = acc & pwrite & pready;
  wire test_new = wr & hit_psc & halted_r;
  wire apb_we   = wr & hit_desc;

  assign pready  = ~hit_desc | desc_ok;
  assign pslverr = acc & ~hit_any;
  assign prdata  = prdata_r;
  assign rdata   = hit_cmd  ? cmd_r :
                   hit_sts  ? {19'h0, halted_r, 10'h0, sts_err_r, sts_int_r} :
                   hit_ien  ? ien_r :
                   hit_cfg  ? {31'h0, cfg_r} :
                   hit_psc  ? psc_r :
                   hit_desc ? mem[d_idx] : 32'h0000_0000;

  // ==========================================================================
  // Outputs
  assign irq            = |({sts_err_r, sts_int_r} & ien_r[1:0]);
  assign port_test_mode = psc_r[iso_split_pkg::PSC_TST_LSB +: 3];
  assign port_suspended = psc_r[iso_split_pkg::PSC_SUSP];
  assign port_enabled   = psc_r[iso_split_pkg::PSC_EN] |
                          (port_test_mode == iso_split_pkg::TEST_FORCE);
  assign tt_cmd_valid   = tt_cmd_v_r;
  assign tt_cmd         = tt_cmd_r;

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r     <= iso_split_pkg::CMD_RST;
      ien_r     <= iso_split_pkg::IEN_RST;
      psc_r     <= iso_split_pkg::PSC_RST;
      sts_int_r <= 1'b0;
      sts_err_r <= 1'b0;
      halted_r  <= 1'b1;
      cfg_r     <= 1'b0;
      sw_rst_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (sw_rst_r) begin
      cmd_r     <= iso_split_pkg::CMD_RST;
      ien_r     <= iso_split_pkg::IEN_RST;
      psc_r     <= iso_split_pkg::PSC_RST;
      sts_int_r <= 1'b0;
      sts_err_r <= 1'b0;
      halted_r  <= 1'b1;
      cfg_r     <= 1'b0;
      sw_rst_r  <= 1'b0;
    end else begin
      if (psel & ~(penable & pready)) begin
        prdata_r <= rdata;
      end
      if (wr & hit_cmd) begin
        cmd_r    <= pwdata & ~(32'h1 << iso_split_pkg::CMD_RESET);
        sw_rst_r <= pwdata[iso_split_pkg::CMD_RESET];
      end
      if (wr & hit_ien) begin
        ien_r <= pwdata;
      end
      if (wr & hit_cfg) begin
        cfg_r <= pwdata[0];
      end
      if (wr & hit_psc) begin
        psc_r[iso_split_pkg::PSC_EN]   <= pwdata[iso_split_pkg::PSC_EN];
        psc_r[iso_split_pkg::PSC_SUSP] <= pwdata[iso_split_pkg::PSC_SUSP];
      end
      if (test_new) begin
        psc_r[iso_split_pkg::PSC_TST_LSB +: 3] <= pwdata[iso_split_pkg::PSC_TST_LSB +: 3];
      end
      sts_int_r <= fire[0] | (sts_int_r & ~(wr & hit_sts & pwdata[iso_split_pkg::STS_INT]));
      sts_err_r <= fire[1] | (sts_err_r & ~(wr & hit_sts & pwdata[iso_split_pkg::STS_ERR]));
      halted_r  <= ~cmd_r[iso_split_pkg::CMD_RUN] & (st_r == iso_split_pkg::ST_IDLE);
    end
  end

  // ==========================================================================
  // Sequencer decisions
  assign cur = mem[idx_r];
  assign prv = mem[prv_r];
  assign tgt = back_r ? prv : cur;
  wire sched_on  = cmd_r[iso_split_pkg::CMD_RUN] & cmd_r[iso_split_pkg::CMD_PER_EN];
  wire back_cond = cur.active & cur.cs &
                   ((uf == 3'h0 & ~cur.back_t) | (uf == 3'h1 & ~cur.smask[0]));
  wire ss_go     = cur.active & ~cur.cs & mask_bit(cur.smask, uf);
  wire cs_go     = cur.active & cur.cs & ~back_cond & mask_bit(cur.cmask, uf);
  wire last_idx  = idx_r == 3'(iso_split_pkg::NDESC - 1);
  wire is_last   = last_cs(tgt.cmask, uf);

  always_comb begin
    st_nxt     = st_r;
    idx_nxt    = idx_r;
    prv_nxt    = prv_r;
    sav_nxt    = sav_r;
    back_nxt   = back_r;
    ret_ss_nxt = ret_ss_r;
    cmd_v_nxt  = 1'b0;
    cmd_nxt    = tt_cmd_r;
    fsm_we     = 1'b0;
    fsm_wa     = idx_r;
    wd         = cur;
    ev         = 2'b00;
    case (st_r)
      iso_split_pkg::ST_IDLE: begin
        if (uf_tick & sched_on) begin
          st_nxt  = iso_split_pkg::ST_VISIT;
          idx_nxt = 3'h0;
        end
      end
      iso_split_pkg::ST_VISIT: begin
        if (back_cond) begin
          sav_nxt = cur;
          prv_nxt = cur.back_idx;
          st_nxt  = iso_split_pkg::ST_BACK;
        end else if (ss_go) begin
          fsm_we    = 1'b1;
          wd.cs     = 1'b1;
          cmd_v_nxt = 1'b1;
          cmd_nxt   = '{start: 1'b1, idx: idx_r, xfer: cur.xfer};
          back_nxt  = 1'b0;
          st_nxt    = iso_split_pkg::ST_WAIT;
        end else if (cs_go) begin
          cmd_v_nxt = 1'b1;
          cmd_nxt   = '{start: 1'b0, idx: idx_r, xfer: cur.xfer};
          back_nxt  = 1'b0;
          st_nxt    = iso_split_pkg::ST_WAIT;
        end else begin
          st_nxt  = last_idx ? iso_split_pkg::ST_IDLE : iso_split_pkg::ST_VISIT;
          idx_nxt = idx_r + 3'h1;
        end
      end
      iso_split_pkg::ST_BACK: begin
        fsm_wa     = prv_r;
        wd         = prv;
        ret_ss_nxt = 1'b1;
        st_nxt     = iso_split_pkg::ST_RET;
        if (prv.active & prv.cs & mask_bit(prv.cmask, uf)) begin
          cmd_v_nxt = 1'b1;
          cmd_nxt   = '{start: 1'b0, idx: prv_r, xfer: prv.xfer};
          back_nxt  = 1'b1;
          st_nxt    = iso_split_pkg::ST_WAIT;
        end else if (prv.active & ~prv.cs) begin
          fsm_we    = 1'b1;
          wd.active = 1'b0;
          ev        = 2'b10;
        end else if (prv.active) begin
          ret_ss_nxt = 1'b0;
        end
      end
      iso_split_pkg::ST_WAIT: begin
        if (tt_resp_valid) begin
          fsm_wa = back_r ? prv_r : idx_r;
          wd     = tgt;
          fsm_we = ~tt_cmd_r.start;
          case (tt_resp)
            iso_split_pkg::RSP_DATA: begin
              wd.xfer    = tgt.xfer + 8'h01;
              wd.active  = 1'b0;
              wd.retired = 1'b1;
              ev[0]      = tgt.ioc & ~tt_cmd_r.start;
            end
            iso_split_pkg::RSP_MDATA: begin
              wd.xfer   = tgt.xfer + 8'h01;
              wd.active = ~is_last;
              ev[1]     = is_last & ~tt_cmd_r.start;
            end
            iso_split_pkg::RSP_NYET: begin
              wd.active = ~is_last;
            end
            iso_split_pkg::RSP_ERR: begin
              wd.active = 1'b0;
              ev[1]     = ~tt_cmd_r.start;
            end
            default: begin
              fsm_we = 1'b0;
            end
          endcase
          if (~wd.active) begin
            wd.cs = 1'b0;
          end
          if (back_r) begin
            ret_ss_nxt = fsm_we & ~wd.active;
            st_nxt     = iso_split_pkg::ST_RET;
          end else begin
            st_nxt  = last_idx ? iso_split_pkg::ST_IDLE : iso_split_pkg::ST_VISIT;
            idx_nxt = idx_r + 3'h1;
          end
        end
      end
      iso_split_pkg::ST_RET: begin
        fsm_we  = ret_ss_r;
        wd      = sav_r;
        wd.cs   = 1'b0;
        st_nxt  = last_idx ? iso_split_pkg::ST_IDLE : iso_split_pkg::ST_VISIT;
        idx_nxt = idx_r + 3'h1;
      end
      default: begin
        st_nxt = iso_split_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Sequencer state and descriptor store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= iso_split_pkg::ST_IDLE;
      idx_r      <= 3'h0;
      prv_r      <= 3'h0;
      sav_r      <= '0;
      back_r     <= 1'b0;
      ret_ss_r   <= 1'b0;
      tt_cmd_v_r <= 1'b0;
      tt_cmd_r   <= '0;
      idle_q_r   <= 1'b1;
    end else begin
      st_r       <= sw_rst_r ? iso_split_pkg::ST_IDLE : st_nxt;
      idx_r      <= idx_nxt;
      prv_r      <= prv_nxt;
      sav_r      <= sav_nxt;
      back_r     <= back_nxt;
      ret_ss_r   <= ret_ss_nxt;
      tt_cmd_v_r <= cmd_v_nxt & ~sw_rst_r;
      tt_cmd_r   <= cmd_nxt;
      idle_q_r   <= st_r == iso_split_pkg::ST_IDLE;
    end
  end

  // Software owns the store only while the walker is idle
  always_ff @(posedge pclk) begin
    if (fsm_we & (st_r != iso_split_pkg::ST_IDLE)) begin
      mem[fsm_wa] <= wd;
    end else if (apb_we) begin
      mem[d_idx] <= pwdata;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WALK_START: assert property (st_r == iso_split_pkg::ST_IDLE && uf_tick && sched_on
    && !sw_rst_r |=> st_r == iso_split_pkg::ST_VISIT && idx_r == 3'h0)
    else $error("walk did not start at tick");
  AST_CMASK_IGNORED: assert property (st_r == iso_split_pkg::ST_VISIT && cur.active && !cur.cs
    && !mask_bit(cur.smask, uf) |=> !tt_cmd_valid)
    else $error("split issued in start state without start mask bit");
  AST_START_SPLIT: assert property (st_r == iso_split_pkg::ST_VISIT && ss_go && !back_cond
    && !sw_rst_r |=> tt_cmd_valid && tt_cmd.start && mem[$past(idx_r)].cs)
    else $error("start-split not issued or state not advanced");
  AST_COMPLETE_SPLIT: assert property (st_r == iso_split_pkg::ST_VISIT && cs_go && !sw_rst_r
    |=> tt_cmd_valid && !tt_cmd.start && tt_cmd.idx == $past(idx_r))
    else $error("complete-split not issued");
  AST_BACK_LINK: assert property (st_r == iso_split_pkg::ST_VISIT && back_cond && !sw_rst_r
    |=> st_r == iso_split_pkg::ST_BACK && prv_r == $past(cur.back_idx))
    else $error("back link not followed");
  AST_BACK_UF1: assert property (st_r == iso_split_pkg::ST_VISIT && uf == 3'h1 && cur.active
    && cur.cs && !cur.smask[0] && !sw_rst_r |=> st_r == iso_split_pkg::ST_BACK)
    else $error("micro-frame 1 back link not followed");
  AST_NO_RECURSE: assert property (st_r == iso_split_pkg::ST_BACK
    |=> st_r != iso_split_pkg::ST_BACK)
    else $error("back link chain walked");
  AST_RET_START: assert property (st_r == iso_split_pkg::ST_RET && ret_ss_r
    |=> !mem[$past(idx_r)].cs)
    else $error("current descriptor not returned to start state");
  AST_MDATA_KEEP: assert property (st_r == iso_split_pkg::ST_WAIT && back_r && tt_resp_valid
    && tt_resp == iso_split_pkg::RSP_MDATA && !is_last && !sw_rst_r
    |=> mem[prv_r].active && !ret_ss_r && mem[idx_r] == $past(mem[idx_r]))
    else $error("MDATA back completion disturbed state");
  AST_THRESHOLD: assert property ($rose(sts_int_r) |-> $past(fire[0]))
    else $error("completion interrupt outside threshold");
  AST_W1C: assert property (wr && hit_sts && pwdata[iso_split_pkg::STS_INT] && !fire[0]
    && !sw_rst_r |=> !sts_int_r)
    else $error("status bit not cleared by one");

  COV_START_SPLIT: cover property (tt_cmd_valid && tt_cmd.start);
  COV_BACK_DONE: cover property (st_r == iso_split_pkg::ST_RET && ret_ss_r);
  COV_IRQ: cover property ($rose(irq));
  COV_TEST_MODE: cover property (port_test_mode == iso_split_pkg::TEST_FORCE);
endmodule
`default_nettype wire

// [iso_tt_model.sv]
// Behavioural transaction translator answering split commands
`default_nettype none
module iso_tt_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    tt_cmd_valid,
  input  wire iso_split_pkg::tt_cmd_s  tt_cmd,
  input  wire iso_split_pkg::tt_resp_e cs_resp,
  input  wire logic [3:0]              dly,
  output logic                         tt_resp_valid,
  output iso_split_pkg::tt_resp_e      tt_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]              cnt;
  logic                    busy;
  iso_split_pkg::tt_resp_e held;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      tt_resp_valid <= 1'b0;
      tt_resp <= iso_split_pkg::RSP_ERR;
    end else begin
      tt_resp_valid <= 1'b0;
      // Released code is scrambled so a stale value is never trusted
      if (tt_resp_valid) tt_resp <= iso_split_pkg::tt_resp_e'(~tt_resp);
      if (tt_cmd_valid) begin
        busy <= 1'b1;
        cnt <= dly;
        held <= tt_cmd.start ? iso_split_pkg::RSP_ACK : cs_resp;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        tt_resp_valid <= 1'b1;
        tt_resp <= held;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_iso_split_txn_sequencer.sv]
// Self-checking testbench for the isochronous split sequencer
`default_nettype none
module tb_iso_split_txn_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic                   tt_cmd_valid, tt_resp_valid, irq, port_suspended, port_enabled;
  iso_split_pkg::tt_cmd_s  tt_cmd, cmd;
  iso_split_pkg::tt_resp_e tt_resp;
  logic [2:0]             port_test_mode;
  int                     failures = 0;
  int                     compares = 0;
  iso_split_txn_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tt_cmd_valid(tt_cmd_valid), .tt_cmd(tt_cmd),
    .tt_resp_valid(tt_resp_valid), .tt_resp(tt_resp), .irq(irq),
    .port_test_mode(port_test_mode), .port_suspended(port_suspended),
    .port_enabled(port_enabled));
  iso_tt_model i_tt (.pclk(pclk), .presetn(presetn), .tt_cmd_valid(tt_cmd_valid),
    .tt_cmd(tt_cmd), .cs_resp(iso_split_pkg::RSP_DATA), .dly(4'h9),
    .tt_resp_valid(tt_resp_valid), .tt_resp(tt_resp));
  // ==========================================================================
  // Shared tasks
  task automatic give_verdict;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cmd;
    @(posedge pclk);
    while (tt_cmd_valid !== 1'b1) @(posedge pclk);
    cmd = tt_cmd;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic reset_values;
    logic [31:0] q;
    logic        e;
    apb(1'b0, iso_split_pkg::OFS_CMD, 32'h0, q, e);
    chk("cmd reset", iso_split_pkg::CMD_RST, q);
    apb(1'b0, iso_split_pkg::OFS_STS, 32'h0, q, e);
    chk("halted", 32'h1, 32'(q[iso_split_pkg::STS_HALT]));
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
  endtask
  task automatic test_modes;
    logic [31:0] q;
    logic        e;
    for (int m = 1; m <= 5; m++) begin
      apb(1'b1, iso_split_pkg::OFS_PSC, (32'(m) << 16) | 32'h80, q, e);
      @(negedge pclk);
      chk("test mode", 32'(m), 32'(port_test_mode));
      chk("suspended", 32'h1, 32'(port_suspended));
    end
    chk("forced enable", 32'h1, 32'(port_enabled));
    apb(1'b1, iso_split_pkg::OFS_CMD, 32'h1, q, e);
    apb(1'b1, iso_split_pkg::OFS_PSC, 32'h80, q, e);
    @(negedge pclk);
    chk("test kept running", 32'h5, 32'(port_test_mode));
    chk("force runs", 32'h1, 32'(port_enabled));
    apb(1'b1, iso_split_pkg::OFS_CMD, 32'h0, q, e);
    apb(1'b1, iso_split_pkg::OFS_CMD, 32'h2, q, e);
    @(posedge pclk);
    @(negedge pclk);
    chk("test exit", 32'h0, 32'(port_test_mode));
  endtask
  task automatic split_flow;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 8; i++) apb(1'b1, iso_split_pkg::OFS_DESC + 12'(4 * i), 32'h0, q, e);
    apb(1'b1, iso_split_pkg::OFS_DESC, 32'h00c3_1045, q, e);
    // Follower in complete state, back link to an idle slot
    apb(1'b1, iso_split_pkg::OFS_DESC + 12'h004, 32'h00c3_103b, q, e);
    apb(1'b1, iso_split_pkg::OFS_IEN, 32'h1, q, e);
    apb(1'b1, iso_split_pkg::OFS_CMD, 32'h0008_0011, q, e);
    wait_cmd;
    chk("first is start", 32'h8, 32'({cmd.start, cmd.idx}));
    wait_cmd;
    chk("wrapped start", 32'h9, 32'({cmd.start, cmd.idx}));
    wait_cmd;
    chk("then complete", 32'h0, 32'({cmd.start, cmd.idx}));
    @(posedge pclk);
    while (tt_resp_valid !== 1'b1) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("irq deferred", 32'h0, 32'(irq));
    for (int n = 0; n < 9 * iso_split_pkg::UF_CYCLES && irq !== 1'b1; n++) @(posedge pclk);
    chk("irq at threshold", 32'h1, 32'(irq));
    apb(1'b0, iso_split_pkg::OFS_DESC, 32'h0, q, e);
    chk("retired active", 32'h0, 32'(q[0]));
    apb(1'b0, iso_split_pkg::OFS_DESC + 12'h004, 32'h0, q, e);
    chk("follower done", 32'h01c3_10b8, q);
    apb(1'b1, iso_split_pkg::OFS_STS, 32'h1, q, e);
    apb(1'b0, iso_split_pkg::OFS_STS, 32'h0, q, e);
    chk("usbint cleared", 32'h0, 32'(q[iso_split_pkg::STS_INT]));
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, iso_split_pkg::OFS_CMD, 32'h0008_0000, q, e);
  endtask
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reset_values;
    test_modes;
    split_flow;
    give_verdict;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
